/* design/ddc_config_regs.sv */
// dac datapath configuration bank with axi4-lite slave and datapath
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module ddc_config_regs (
	input  wire logic                         I_CLK_SYS,   // 50 mhz
	input  wire logic                         I_RESET_N,   // sync, low
	input  wire logic                         I_AWVALID,   // aw valid
	output logic                              O_AWREADY,   // aw ready
	input  wire logic [ddc_pkg::ADDR_W-1:0]   I_AWADDR,    // aw address
	input  wire logic                         I_WVALID,    // w valid
	output logic                              O_WREADY,    // w ready
	input  wire logic [ddc_pkg::DATA_W-1:0]   I_WDATA,     // w data
	input  wire logic [3:0]                   I_WSTRB,     // w strobes
	output logic                              O_BVALID,    // b valid
	input  wire logic                         I_BREADY,    // b ready
	output logic      [1:0]                   O_BRESP,     // b response
	input  wire logic                         I_ARVALID,   // ar valid
	output logic                              O_ARREADY,   // ar ready
	input  wire logic [ddc_pkg::ADDR_W-1:0]   I_ARADDR,    // ar address
	output logic                              O_RVALID,    // r valid
	input  wire logic                         I_RREADY,    // r ready
	output logic      [ddc_pkg::DATA_W-1:0]   O_RDATA,     // r data
	output logic      [1:0]                   O_RRESP,     // r response
	input  wire logic [ddc_pkg::SAMPLE_W-1:0] I_SAMPLE_A,  // chan a word
	input  wire logic [ddc_pkg::SAMPLE_W-1:0] I_SAMPLE_B,  // chan b word
	input  wire logic                         I_ALIGN_N,   // strobe pin
	input  wire logic                         I_TX_PIN,    // transmit pin
	output logic      [ddc_pkg::SAMPLE_W-1:0] O_LEVEL_A,   // chan a out
	output logic      [ddc_pkg::SAMPLE_W-1:0] O_LEVEL_B,   // chan b out
	output logic      [ddc_pkg::PHASE_W-1:0]  O_PHASE,     // period phase
	output logic                              O_ALIGN_STB, // strobe used
	output logic                              O_TERM_ON,   // termination
	output logic      [ddc_pkg::CUR_W-1:0]    O_COARSE_A,  // chan a level
	output logic      [ddc_pkg::CUR_W-1:0]    O_COARSE_B,  // chan b level
	output logic                              O_DUAL_CLK,  // dual clock
	output logic                              O_DP_RUN     // datapath on
);

	// ****************************************
	// bus slave state
	// ****************************************
	logic                       aw_held, next_aw_held; // address taken
	logic [ddc_pkg::IDX_W-1:0]  aw_idx, next_aw_idx;   // write index
	logic                       w_held, next_w_held;   // data taken
	logic [ddc_pkg::REG_W-1:0]  w_byte, next_w_byte;   // write byte
	logic                       w_lane, next_w_lane;   // lane 0 strobe
	logic                       next_awready;          // aw ready
	logic                       next_wready;           // w ready
	logic                       next_bvalid;           // b valid
	logic [1:0]                 next_bresp;            // b response
	logic                       next_arready;          // ar ready
	logic                       next_rvalid;           // r valid
	logic [ddc_pkg::DATA_W-1:0] next_rdata;            // r data
	logic [1:0]                 next_rresp;            // r response
	logic                       commit;                // write applies
	logic [ddc_pkg::IDX_W-1:0]  ar_idx;                // read index
	logic [ddc_pkg::REG_W-1:0]  rd_byte;               // read value
	logic                       rd_hit;                // read mapped
	logic                       wr_hit;                // write mapped

	// ****************************************
	// register bank
	// ****************************************
	logic [ddc_pkg::REG_W-1:0] word_cfg, next_word_cfg;   // resolution
	logic [ddc_pkg::REG_W-1:0] term, next_term;           // termination
	logic [ddc_pkg::REG_W-1:0] dither, next_dither;       // dither spans
	logic [ddc_pkg::REG_W-1:0] fmt, next_fmt;             // pulse format
	logic [ddc_pkg::REG_W-1:0] coarse, next_coarse;       // coarse level
	logic [ddc_pkg::REG_W-1:0] ctrl, next_ctrl;           // run, tx, dcm
	logic [ddc_pkg::REG_W-1:0] status;                    // read view

	// ****************************************
	// datapath state
	// ****************************************
	logic [2:0] align_sync, next_align_sync;  // strobe pin stages
	logic [2:0] tx_sync, next_tx_sync;        // transmit pin stages
	logic       align_low, next_align_low;    // filtered strobe pin
	logic       tx_high, next_tx_high;        // filtered transmit pin
	logic [ddc_pkg::PHASE_W-1:0] next_phase;  // phase counter
	logic       next_stb;                     // strobe in use
	logic       run;                          // datapath released
	logic       tx_on;                        // pin or register
	logic       dp_reset_n;                   // datapath reset
	logic [ddc_pkg::SAMPLE_W-1:0] word_a;     // chan a word, strobe out
	logic [ddc_pkg::SAMPLE_W-1:0] word_b;     // chan b word, strobe out

	// decode only the index bits; the byte offset inside a word is ignored
	assign ar_idx = I_ARADDR[ddc_pkg::ADDR_W-1:ddc_pkg::IDX_LSB];
	assign commit = aw_held & w_held & ~O_BVALID;

	// read mux; status is read-only and reflects live datapath state
	always_comb begin
		status = '0;
		status[ddc_pkg::ST_RUN_BIT] = run;
		status[ddc_pkg::ST_TX_BIT]  = tx_on;
		status[ddc_pkg::ST_STB_BIT] = O_ALIGN_STB;
		status[ddc_pkg::ST_PH_LO +: ddc_pkg::PHASE_W] = O_PHASE;
		rd_hit  = 1'b1;
		case (ar_idx)
			ddc_pkg::IDX_INPUT_WORD_CONFIG:     rd_byte = word_cfg;
			ddc_pkg::IDX_INPUT_TERMINATION:     rd_byte = term;
			ddc_pkg::IDX_DITHER_AMOUNT:         rd_byte = dither;
			ddc_pkg::IDX_OUTPUT_PULSE_FORMAT:   rd_byte = fmt;
			ddc_pkg::IDX_COARSE_OUTPUT_CURRENT: rd_byte = coarse;
			ddc_pkg::IDX_CONTROL:               rd_byte = ctrl;
			ddc_pkg::IDX_STATUS:                rd_byte = status;
			default: begin                  // unmapped: zero, error
				rd_byte = '0;
				rd_hit  = 1'b0;
			end
		endcase
	end

	// axi handshakes; one write and one read in flight at most
	always_comb begin
		next_aw_held = aw_held;
		next_aw_idx  = aw_idx;
		next_w_held  = w_held;
		next_w_byte  = w_byte;
		next_w_lane  = w_lane;
		next_bvalid  = O_BVALID;
		next_bresp   = O_BRESP;
		next_rvalid  = O_RVALID;
		next_rdata   = O_RDATA;
		next_rresp   = O_RRESP;
		case (aw_idx)                        // status accepts and ignores
			ddc_pkg::IDX_INPUT_WORD_CONFIG, ddc_pkg::IDX_INPUT_TERMINATION,
			ddc_pkg::IDX_DITHER_AMOUNT, ddc_pkg::IDX_OUTPUT_PULSE_FORMAT,
			ddc_pkg::IDX_COARSE_OUTPUT_CURRENT, ddc_pkg::IDX_CONTROL,
			ddc_pkg::IDX_STATUS: wr_hit = 1'b1;
			default:             wr_hit = 1'b0;
		endcase
		// address and data are taken independently, in either order
		if (I_AWVALID && O_AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_idx  = I_AWADDR[ddc_pkg::ADDR_W-1:ddc_pkg::IDX_LSB];
		end
		if (I_WVALID && O_WREADY) begin
			next_w_held = 1'b1;
			next_w_byte = I_WDATA[ddc_pkg::REG_W-1:0];
			next_w_lane = I_WSTRB[0];
		end
		if (O_BVALID && I_BREADY) begin
			next_bvalid = 1'b0;
		end
		if (commit) begin                    // both halves present
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? ddc_pkg::RESP_OKAY :
				ddc_pkg::RESP_SLVERR;
		end
		if (O_RVALID && I_RREADY) begin
			next_rvalid = 1'b0;
		end
		if (I_ARVALID && O_ARREADY) begin
			next_rvalid = 1'b1;
			next_rdata  = {{(ddc_pkg::DATA_W-ddc_pkg::REG_W){1'b0}},
				rd_byte};
			next_rresp  = rd_hit ? ddc_pkg::RESP_OKAY :
				ddc_pkg::RESP_SLVERR;
		end
		// readies are registered, so they look one cycle ahead
		next_awready = ~next_aw_held & ~next_bvalid;
		next_wready  = ~next_w_held & ~next_bvalid;
		next_arready = ~next_rvalid;
	end

	// bus slave registers
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			aw_held   <= 1'b0;
			aw_idx    <= '0;
			w_held    <= 1'b0;
			w_byte    <= '0;
			w_lane    <= 1'b0;
			O_AWREADY <= 1'b0;
			O_WREADY  <= 1'b0;
			O_BVALID  <= 1'b0;
			O_BRESP   <= ddc_pkg::RESP_OKAY;
			O_ARREADY <= 1'b0;
			O_RVALID  <= 1'b0;
			O_RDATA   <= '0;
			O_RRESP   <= ddc_pkg::RESP_OKAY;
		end else begin
			aw_held   <= next_aw_held;
			aw_idx    <= next_aw_idx;
			w_held    <= next_w_held;
			w_byte    <= next_w_byte;
			w_lane    <= next_w_lane;
			O_AWREADY <= next_awready;
			O_WREADY  <= next_wready;
			O_BVALID  <= next_bvalid;
			O_BRESP   <= next_bresp;
			O_ARREADY <= next_arready;
			O_RVALID  <= next_rvalid;
			O_RDATA   <= next_rdata;
			O_RRESP   <= next_rresp;
		end
	end

	// register writes; only byte lane 0 carries data
	always_comb begin
		next_word_cfg = word_cfg;
		next_term     = term;
		next_dither   = dither;
		next_fmt      = fmt;
		next_coarse   = coarse;
		next_ctrl     = ctrl;
		if (commit && w_lane) begin
			case (aw_idx)
				ddc_pkg::IDX_INPUT_WORD_CONFIG:     next_word_cfg = w_byte;
				ddc_pkg::IDX_INPUT_TERMINATION:     next_term     = w_byte;
				// no lockout: changing these live is the caller's risk
				ddc_pkg::IDX_DITHER_AMOUNT:         next_dither   = w_byte;
				ddc_pkg::IDX_OUTPUT_PULSE_FORMAT:   next_fmt      = w_byte;
				ddc_pkg::IDX_COARSE_OUTPUT_CURRENT: next_coarse   = w_byte;
				ddc_pkg::IDX_CONTROL:               next_ctrl     = w_byte;
				default: ;                          // status, unmapped
			endcase
		end
	end

	// register bank storage
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			word_cfg <= ddc_pkg::RST_INPUT_WORD_CONFIG;
			term     <= ddc_pkg::RST_INPUT_TERMINATION;
			dither   <= ddc_pkg::RST_DITHER_AMOUNT;
			fmt      <= ddc_pkg::RST_OUTPUT_PULSE_FORMAT;
			coarse   <= ddc_pkg::RST_COARSE_OUTPUT_CURRENT;
			ctrl     <= ddc_pkg::RST_CONTROL;
		end else begin
			word_cfg <= next_word_cfg;
			term     <= next_term;
			dither   <= next_dither;
			fmt      <= next_fmt;
			coarse   <= next_coarse;
			ctrl     <= next_ctrl;
		end
	end

	// ****************************************
	// datapath control
	// ****************************************
	assign run        = ctrl[ddc_pkg::CTRL_RUN_BIT];
	assign tx_on      = ctrl[ddc_pkg::CTRL_TX_BIT] | tx_high;
	assign dp_reset_n = I_RESET_N & run;
	// with the lsb used as strobe it carries no sample weight
	assign word_a = word_cfg[ddc_pkg::LSB_SYNC_BIT] ?
		{I_SAMPLE_A[ddc_pkg::SAMPLE_W-1:1], 1'b0} : I_SAMPLE_A;
	assign word_b = word_cfg[ddc_pkg::LSB_SYNC_BIT] ?
		{I_SAMPLE_B[ddc_pkg::SAMPLE_W-1:1], 1'b0} : I_SAMPLE_B;

	// pin filters, phase counter and strobe select
	always_comb begin
		next_align_sync = {align_sync[1:0], I_ALIGN_N};
		next_tx_sync    = {tx_sync[1:0], I_TX_PIN};
		next_align_low  = align_low;
		next_tx_high    = tx_high;
		// a pin change counts once stages two and three agree
		if (align_sync[1] == align_sync[2]) begin
			next_align_low = ~align_sync[2];
		end
		if (tx_sync[1] == tx_sync[2]) begin
			next_tx_high = tx_sync[2];
		end
		next_phase = run ? O_PHASE + 2'h1 : ddc_pkg::PH_Q0;
		if (!run) begin
			next_stb = 1'b0;
		end else if (word_cfg[ddc_pkg::LSB_SYNC_BIT]) begin
			next_stb = I_SAMPLE_A[0];
		end else begin
			next_stb = next_align_low;
		end
	end

	// datapath control registers and configuration outputs
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			align_sync  <= 3'h7;
			tx_sync     <= 3'h0;
			align_low   <= 1'b0;
			tx_high     <= 1'b0;
			O_PHASE     <= ddc_pkg::PH_Q0;
			O_ALIGN_STB <= 1'b0;
			O_TERM_ON   <= ddc_pkg::RST_INPUT_TERMINATION[ddc_pkg::TERM_BIT];
			O_COARSE_A  <= '0;
			O_COARSE_B  <= '0;
			O_DUAL_CLK  <= 1'b0;
			O_DP_RUN    <= 1'b0;
		end else begin
			align_sync  <= next_align_sync;
			tx_sync     <= next_tx_sync;
			align_low   <= next_align_low;
			tx_high     <= next_tx_high;
			O_PHASE     <= next_phase;
			O_ALIGN_STB <= next_stb;
			O_TERM_ON   <= next_term[ddc_pkg::TERM_BIT];
			// coarse fields feed the current dacs directly
			O_COARSE_A  <= next_coarse[ddc_pkg::CUR_A_LO +: ddc_pkg::CUR_W];
			O_COARSE_B  <= next_coarse[ddc_pkg::CUR_B_LO +: ddc_pkg::CUR_W];
			O_DUAL_CLK  <= next_ctrl[ddc_pkg::CTRL_DCM_BIT];
			O_DP_RUN    <= next_ctrl[ddc_pkg::CTRL_RUN_BIT];
		end
	end

	// ****************************************
	// channel shapers
	// ****************************************
	ddc_chan_shaper #(.SEED(ddc_pkg::SEED_A)) u_chan_a (
		.i_clk     (I_CLK_SYS),
		.i_reset_n (dp_reset_n),
		.i_phase   (O_PHASE),
		.i_sample  (word_a),
		.i_res     (word_cfg[ddc_pkg::RES_HI:ddc_pkg::RES_LO]),
		.i_dith    (dither[ddc_pkg::DITH_A_LO +: 2]),
		.i_fmt     (fmt[ddc_pkg::FMT_A_LO +: 2]),
		.i_tx      (tx_on),
		.o_level   (O_LEVEL_A)
	);

	ddc_chan_shaper #(.SEED(ddc_pkg::SEED_B)) u_chan_b (
		.i_clk     (I_CLK_SYS),
		.i_reset_n (dp_reset_n),
		.i_phase   (O_PHASE),
		.i_sample  (word_b),
		.i_res     (word_cfg[ddc_pkg::RES_HI:ddc_pkg::RES_LO]),
		.i_dith    (dither[ddc_pkg::DITH_B_LO +: 2]),
		.i_fmt     (fmt[ddc_pkg::FMT_B_LO +: 2]),
		.i_tx      (tx_on),
		.o_level   (O_LEVEL_B)
	);

endmodule : ddc_config_regs

/* design/ddc_pkg.sv */
// constants and types shared by the dac datapath configuration bank
package ddc_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int ADDR_W   = 12;   // axi byte address width
	localparam int DATA_W   = 32;   // axi data width
	localparam int REG_W    = 8;    // width of every bank register
	localparam int IDX_W    = 10;   // register index width
	localparam int IDX_LSB  = 2;    // byte address = index * 4
	localparam int SAMPLE_W = 12;   // converter sample width
	localparam int LFSR_W   = 16;   // dither generator width
	localparam int PHASE_W  = 2;    // four phases per sample period

	// ****************************************
	// register indices (byte address = index * 4)
	// ****************************************
	localparam logic [IDX_W-1:0] IDX_INPUT_WORD_CONFIG     = 10'h106;
	localparam logic [IDX_W-1:0] IDX_INPUT_TERMINATION     = 10'h107;
	localparam logic [IDX_W-1:0] IDX_DITHER_AMOUNT         = 10'h140;
	localparam logic [IDX_W-1:0] IDX_OUTPUT_PULSE_FORMAT   = 10'h160;
	localparam logic [IDX_W-1:0] IDX_COARSE_OUTPUT_CURRENT = 10'h170;
	localparam logic [IDX_W-1:0] IDX_CONTROL               = 10'h1f0;
	localparam logic [IDX_W-1:0] IDX_STATUS                = 10'h1f1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [REG_W-1:0] RST_INPUT_WORD_CONFIG     = 8'h00;
	localparam logic [REG_W-1:0] RST_INPUT_TERMINATION     = 8'h01;
	localparam logic [REG_W-1:0] RST_DITHER_AMOUNT         = 8'h00;
	localparam logic [REG_W-1:0] RST_OUTPUT_PULSE_FORMAT   = 8'h00;
	localparam logic [REG_W-1:0] RST_COARSE_OUTPUT_CURRENT = 8'h00;
	localparam logic [REG_W-1:0] RST_CONTROL               = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int RES_HI       = 6;  // resolution select
	localparam int RES_LO       = 4;
	localparam int LSB_SYNC_BIT = 0;  // strobe from data lsb
	localparam int TERM_BIT     = 0;  // 100 ohm termination
	localparam int DITH_A_LO    = 0;  // chan_a_dither_span
	localparam int DITH_B_LO    = 2;  // chan_b_dither_span
	localparam int FMT_A_LO     = 0;  // chan_a_pulse_format
	localparam int FMT_B_LO     = 4;  // chan_b_pulse_format
	localparam int CUR_A_LO     = 0;  // chan_a_coarse_level
	localparam int CUR_B_LO     = 4;  // chan_b_coarse_level
	localparam int CUR_W        = 4;
	localparam int CTRL_RUN_BIT = 0;  // datapath_run
	localparam int CTRL_DCM_BIT = 1;  // dual_clock_mode_on
	localparam int CTRL_TX_BIT  = 2;  // transmit_gate, register half
	localparam int ST_RUN_BIT   = 0;  // status: datapath running
	localparam int ST_TX_BIT    = 1;  // status: transmit gate in force
	localparam int ST_STB_BIT   = 2;  // status: alignment strobe
	localparam int ST_PH_LO     = 4;  // status: current phase

	// ****************************************
	// encodings
	// ****************************************
	typedef enum logic [1:0] {
		FMT_NRZ  = 2'b00,     // sample for the whole period
		FMT_RTI  = 2'b01,     // sample, then its inverse
		FMT_RTZ  = 2'b10,     // sample, then zero
		FMT_2XRF = 2'b11      // zero, sample, inverse, zero
	} ddc_fmt_e;

	typedef enum logic [1:0] {
		DITH_OFF = 2'b00,     // no dither
		DITH_S1  = 2'b01,     // +1 .. -2 lsb
		DITH_S2  = 2'b10,     // +3 .. -4 lsb
		DITH_S3  = 2'b11      // +7 .. -8 lsb
	} ddc_dith_e;

	localparam logic [2:0] RES_MAX_DROP = 3'h4;   // >3 means 8-bit
	localparam logic [PHASE_W-1:0] PH_Q0 = 2'h0;
	localparam logic [PHASE_W-1:0] PH_Q1 = 2'h1;
	localparam logic [PHASE_W-1:0] PH_Q2 = 2'h2;
	localparam logic [PHASE_W-1:0] PH_Q3 = 2'h3;
	localparam logic [SAMPLE_W-1:0] MIDSCALE = 12'h800; // analog zero
	localparam logic [SAMPLE_W-1:0] FULL_MASK = 12'hfff;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [LFSR_W-1:0] SEED_A = 16'hace1;
	localparam logic [LFSR_W-1:0] SEED_B = 16'h5b37;

endpackage : ddc_pkg

/* design/ddc_chan_shaper.sv */
// one converter channel: resolution, dither and pulse format
`timescale 1ns/10ps
module ddc_chan_shaper #(
	parameter logic [ddc_pkg::LFSR_W-1:0] SEED = ddc_pkg::SEED_A
) (
	input  wire logic                          i_clk,    // system clock
	input  wire logic                          i_reset_n,// sync, low
	input  wire logic [ddc_pkg::PHASE_W-1:0]   i_phase,  // period phase
	input  wire logic [ddc_pkg::SAMPLE_W-1:0]  i_sample, // input word
	input  wire logic [2:0]                    i_res,    // resolution
	input  wire logic [1:0]                    i_dith,   // dither span
	input  wire logic [1:0]                    i_fmt,    // pulse format
	input  wire logic                          i_tx,     // transmit on
	output logic      [ddc_pkg::SAMPLE_W-1:0]  o_level   // output code
);

	// ****************************************
	// state
	// ****************************************
	logic [ddc_pkg::LFSR_W-1:0]   lfsr, next_lfsr;   // dither source
	logic [ddc_pkg::SAMPLE_W-1:0] held, next_held;   // current sample
	logic [ddc_pkg::SAMPLE_W-1:0] next_level;        // next output
	logic [2:0]                   drop;              // lsbs discarded
	logic [ddc_pkg::SAMPLE_W-1:0] masked;            // truncated word
	logic signed [4:0]            dith;              // signed dither
	logic signed [13:0]           sum;               // dithered word

	// sample load, dither and phase shaping
	always_comb begin
		next_lfsr  = lfsr;
		next_held  = held;
		drop       = (i_res > ddc_pkg::RES_MAX_DROP) ?
			ddc_pkg::RES_MAX_DROP : i_res;
		masked     = i_sample & (ddc_pkg::FULL_MASK << drop);
		// a new word and a new dither value once per period
		case (ddc_pkg::ddc_dith_e'(i_dith))
			ddc_pkg::DITH_S1: dith = {{3{lfsr[1]}}, lfsr[1:0]};
			ddc_pkg::DITH_S2: dith = {{2{lfsr[2]}}, lfsr[2:0]};
			ddc_pkg::DITH_S3: dith = {lfsr[3], lfsr[3:0]};
			default:          dith = 5'sh00;
		endcase
		sum = $signed({2'b00, masked}) + 14'(dith);
		if (i_phase == ddc_pkg::PH_Q0) begin
			next_lfsr = {lfsr[14:0],
				lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			// clamp so dither never wraps a full-scale code
			if (sum < 14'sh0000) begin
				next_held = '0;
			end else if (sum > 14'sh0fff) begin
				next_held = ddc_pkg::FULL_MASK;
			end else begin
				next_held = sum[ddc_pkg::SAMPLE_W-1:0];
			end
		end
		// shape the four phases of the period
		case (ddc_pkg::ddc_fmt_e'(i_fmt))
			ddc_pkg::FMT_NRZ: next_level = next_held;
			ddc_pkg::FMT_RTI: next_level = (i_phase < ddc_pkg::PH_Q2) ?
				next_held : ~next_held;
			ddc_pkg::FMT_RTZ: next_level = (i_phase < ddc_pkg::PH_Q2) ?
				next_held : ddc_pkg::MIDSCALE;
			ddc_pkg::FMT_2XRF: begin
				case (i_phase)
					ddc_pkg::PH_Q1: next_level = next_held;
					ddc_pkg::PH_Q2: next_level = ~next_held;
					default:        next_level = ddc_pkg::MIDSCALE;
				endcase
			end
			default: next_level = next_held;
		endcase
		// muted channel sits at analog zero
		if (!i_tx) begin
			next_level = ddc_pkg::MIDSCALE;
		end
	end

	// register stage; reset also covers datapath hold
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			lfsr    <= SEED;
			held    <= ddc_pkg::MIDSCALE;
			o_level <= ddc_pkg::MIDSCALE;
		end else begin
			lfsr    <= next_lfsr;
			held    <= next_held;
			o_level <= next_level;
		end
	end

endmodule : ddc_chan_shaper

/* verif/ddc_props.sv */
// checker: bus handshake and datapath idle properties
`timescale 1ns/10ps
module ddc_props (
	input wire logic        I_CLK_SYS, // clock
	input wire logic        I_RESET_N, // reset
	input wire logic        O_AWREADY, // aw ready
	input wire logic        O_WREADY,  // w ready
	input wire logic        O_BVALID,  // b valid
	input wire logic        I_BREADY,  // b ready
	input wire logic [1:0]  O_BRESP,   // b resp
	input wire logic        I_ARVALID, // ar valid
	input wire logic        O_ARREADY, // ar ready
	input wire logic        O_RVALID,  // r valid
	input wire logic        I_RREADY,  // r ready
	input wire logic [31:0] O_RDATA,   // r data
	input wire logic [1:0]  O_PHASE,   // phase
	input wire logic [11:0] O_LEVEL_A, // chan a out
	input wire logic        O_DP_RUN   // datapath on
);
	// ****************************************
	// properties, one clock domain
	// ****************************************
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);
	property p_bh; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
	endproperty
	a_bh: assert property (p_bh) else $error("write response dropped");
	property p_rh; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
	endproperty
	a_rh: assert property (p_rh) else $error("read data dropped");
	property p_rl; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
	a_rl: assert property (p_rl) else $error("read answer late");
	property p_rz; O_RVALID |-> O_RDATA[31:8] == 24'h0; endproperty
	a_rz: assert property (p_rz) else $error("upper read bits set");
	property p_wl; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
	a_wl: assert property (p_wl) else $error("write taken while busy");
	property p_al; O_RVALID |-> !O_ARREADY; endproperty
	a_al: assert property (p_al) else $error("read taken while busy");
	// stopped datapath sits at phase 0 and analog zero
	property p_id; !O_DP_RUN && !$past(O_DP_RUN) |->
		O_PHASE == 2'h0 && O_LEVEL_A == 12'h800; endproperty
	a_id: assert property (p_id) else $error("idle datapath moved");
	property p_ph; O_DP_RUN && $past(O_DP_RUN, 2) |->
		O_PHASE == $past(O_PHASE) + 2'h1; endproperty
	a_ph: assert property (p_ph) else $error("phase not counting");
	cover property (O_BVALID && I_BREADY);
	cover property (O_RVALID && I_RREADY);
	cover property (O_DP_RUN && O_PHASE == 2'h3);
endmodule : ddc_props

/* verif/test_ddc_config_regs.sv */
// bench: register bank access and channel shaping
`timescale 1ns/10ps
module test_ddc_config_regs;
	logic I_CLK_SYS = 1'h0, I_RESET_N = 1'h0, I_AWVALID = 1'h0;
	logic I_WVALID = 1'h0, I_BREADY = 1'h0, I_ARVALID = 1'h0;
	logic I_RREADY = 1'h0, I_ALIGN_N = 1'h1, I_TX_PIN = 1'h0;
	logic [11:0] I_AWADDR = 12'h0, I_ARADDR = 12'h0, mk;
	logic [11:0] I_SAMPLE_A = 12'h0, I_SAMPLE_B = 12'h0, O_LEVEL_A, O_LEVEL_B;
	logic [31:0] I_WDATA = 32'h0, O_RDATA, w;
	logic [3:0]  I_WSTRB = 4'hf, O_COARSE_A, O_COARSE_B;
	logic [1:0]  O_BRESP, O_RRESP, O_PHASE;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_ALIGN_STB;
	logic O_TERM_ON, O_DUAL_CLK, O_DP_RUN;
	int n_fail = 0, checks_done = 0, seed = 32'h057399bb, dv, j;
	logic [7:0]  m [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00}; // bank image
	localparam logic [11:0] AD [5] = '{12'h418, 12'h41c, 12'h500, 12'h580,
		12'h5c0};
	ddc_config_regs i_dut (.*);
	always #10 I_CLK_SYS = ~I_CLK_SYS;
	initial begin // watchdog, far beyond the planned run
		repeat (20000) @(posedge I_CLK_SYS);
		n_fail++;
		conclude;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		I_AWADDR <= a;
		I_WDATA <= d;
		{I_AWVALID, I_WVALID} <= 2'h3;
		do begin
			@(posedge I_CLK_SYS);
			if (O_AWREADY) I_AWVALID <= 1'h0;
			if (O_WREADY) I_WVALID <= 1'h0;
			// response left waiting one edge so its hold is exercised
			if (O_BVALID && !I_BREADY) I_BREADY <= 1'h1;
		end while ((O_BVALID & I_BREADY) !== 1'h1);
		I_BREADY <= 1'h0;
		chk(32'(O_BRESP), 32'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		I_ARADDR <= a;
		I_ARVALID <= 1'h1;
		do begin
			@(posedge I_CLK_SYS);
			if (O_ARREADY) I_ARVALID <= 1'h0;
			// read data left waiting one edge so its hold is exercised
			if (O_RVALID && !I_RREADY) I_RREADY <= 1'h1;
		end while ((O_RVALID & I_RREADY) !== 1'h1);
		I_RREADY <= 1'h0;
		chk(O_RDATA, d);
		chk(32'(O_RRESP), 32'(r));
	endtask : rd
	// shaped value of one phase for each pulse format
	function automatic logic [11:0] ex(int f, logic [11:0] s, int p);
		case (f)
			1: return (p < 2) ? s : ~s;
			2: return (p < 2) ? s : 12'h800;
			3: return (p == 1) ? s : (p == 2) ? ~s : 12'h800;
			default: return s;
		endcase
	endfunction : ex
	task automatic conclude;
		$display("mismatches %0d checks %0d", n_fail, checks_done);
		if (n_fail == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (20) @(posedge I_CLK_SYS);
		I_RESET_N <= 1'h1;
		@(posedge I_CLK_SYS);
		chk(32'(O_TERM_ON), 32'h1);
		for (int i = 0; i < 17; i++) begin
			j = (i < 5) ? i : unsigned'($random(seed)) % 5;
			if (i >= 5) begin // lane 0 strobe drawn at random
				w = $random(seed);
				I_WSTRB <= {3'h7, w[8]};
				wr(AD[j], w);
				if (w[8]) m[j] = w[7:0];
			end
			rd(AD[j], 32'(m[j]), 2'h0);
		end
		chk({24'h0, O_COARSE_B, O_COARSE_A}, 32'(m[4]));
		chk(32'(O_TERM_ON), 32'(m[1][0]));
		I_WSTRB <= 4'hf;
		rd(12'h004, 32'h0, 2'h2);
		I_SAMPLE_A <= 12'($random(seed));
		I_SAMPLE_B <= 12'($random(seed));
		wr(AD[2], 32'h0);
		for (int k = 0; k < 4; k++) begin // resolution 6,4,2,0 per format
			mk = 12'hfff << ((k < 2) ? 4 : 6 - 2 * k);
			wr(12'h7c0, 32'h0);
			wr(AD[0], 32'((3 - k) * 32));
			wr(AD[3], 32'(k * 17));
			wr(12'h7c0, 32'h7);
			chk({30'h0, O_DUAL_CLK, O_DP_RUN}, 32'h3);
			repeat (8) @(posedge I_CLK_SYS);
			do @(posedge I_CLK_SYS); while (O_PHASE !== 2'h0);
			for (int p = 0; p < 4; p++) begin
				@(posedge I_CLK_SYS);
				chk(32'(O_LEVEL_A), 32'(ex(k, I_SAMPLE_A & mk, p)));
				chk(32'(O_LEVEL_B), 32'(ex(k, I_SAMPLE_B & mk, p)));
			end
		end
		wr(12'h7c0, 32'h0);
		wr(AD[3], 32'h0);
		for (int c = 1; c < 4; c++) begin // dither spans 1 to 3 with transmit on
			wr(12'h7c0, 32'h1);
			wr(AD[2], 32'(c * 5));
			wr(12'h7c0, 32'h5);
			repeat (8) @(posedge I_CLK_SYS);
			repeat (40) begin
				@(posedge I_CLK_SYS);
				dv = int'(O_LEVEL_A) - int'(I_SAMPLE_A);
				chk(32'(dv >= -(1 << c) && dv < (1 << c)), 32'h1);
			end
		end
		wr(12'h7c0, 32'h1);
		rd(12'h7c0, 32'h1, 2'h0);
		chk({30'h0, O_DUAL_CLK, O_DP_RUN}, 32'h1);
		wr(AD[2], 32'h0);
		repeat (8) @(posedge I_CLK_SYS);
		chk(32'(O_LEVEL_A), 32'h800);
		I_TX_PIN <= 1'h1; // transmit and strobe now from the pins
		I_ALIGN_N <= 1'h0;
		repeat (12) @(posedge I_CLK_SYS);
		chk(32'(O_LEVEL_A), 32'(I_SAMPLE_A));
		chk(32'(O_ALIGN_STB), 32'h1);
		wr(AD[0], 32'h1);
		I_SAMPLE_A <= I_SAMPLE_A & 12'hffe;
		repeat (2) @(posedge I_CLK_SYS);
		chk(32'(O_ALIGN_STB), 32'h0);
		I_SAMPLE_A <= I_SAMPLE_A | 12'h001;
		repeat (2) @(posedge I_CLK_SYS);
		chk(32'(O_ALIGN_STB), 32'h1);
		conclude;
	end
endmodule : test_ddc_config_regs
bind ddc_config_regs ddc_props i_props (.*);
